// File: rtl/rfts_if.sv
`timescale 1ns/10ps
// Symbol link between reader and tag, one symbol per valid cycle.
interface rfts_if;
  logic       r2t_vld;
  logic [1:0] r2t_sym;
  logic       r2t_eof;
  logic       t2r_vld;
  logic [1:0] t2r_sym;
  logic       t2r_eof;
  modport tag    (input r2t_vld, r2t_sym, r2t_eof, output t2r_vld, t2r_sym, t2r_eof);
  modport reader (output r2t_vld, r2t_sym, r2t_eof, input t2r_vld, t2r_sym, t2r_eof);
endinterface

// File: rtl/rfts_params.svh
`ifndef RFTS_PARAMS_SVH
`define RFTS_PARAMS_SVH

// Link symbols, one per bit slot.
`define RFTS_SYM_ZERO 2'h0
`define RFTS_SYM_ONE  2'h1
`define RFTS_SYM_NONE 2'h2
`define RFTS_SYM_SOC  2'h3

// Frame limits in bits and bytes, bits per byte slot, and short frame lengths in bits.
`define RFTS_R2T_MAX_BITS   82
`define RFTS_T2R_MAX_BITS   9235
`define RFTS_R2T_MAX_BYTES  4'h9
`define RFTS_R2T_MAX_DATA   4'h7
`define RFTS_R2T_SHORT_BITS 7
`define RFTS_T2R_SHORT_BITS 4
`define RFTS_BYTE_BITS      4'h9

// Checksum.
`define RFTS_CRC_INIT 16'h6363
`define RFTS_CRC_POLY 16'h8408

// Commands and fixed answers.
`define RFTS_REQA      7'h26
`define RFTS_WUPA      7'h52
`define RFTS_CMD_CL1   8'h93
`define RFTS_CMD_CL2   8'h95
`define RFTS_NVB_ANTI  8'h20
`define RFTS_NVB_SEL   8'h70
`define RFTS_CMD_HLTA  8'h50
`define RFTS_CMD_READ  8'h30
`define RFTS_CMD_FREAD 8'h3a
`define RFTS_CMD_WRITE 8'ha2
`define RFTS_CMD_SSEL  8'hc2
`define RFTS_SSEL_ARG  8'hff
`define RFTS_CT        8'h88
`define RFTS_ATQA0     8'h44
`define RFTS_ATQA1     8'h00
`define RFTS_SAK_MORE  8'h04
`define RFTS_SAK_DONE  8'h00
`define RFTS_ACK       8'h0a
`define RFTS_NAK       8'h00
`define RFTS_READ_LEN  11'h010

// Page map of the 1k organization.
`define RFTS_SEC_MAIN     8'h00
`define RFTS_SEC_SES      8'h03
`define RFTS_PG_ROM_LAST  8'h01
`define RFTS_PG_WR_FIRST  8'h02
`define RFTS_PG_MEM_LAST  8'he2
`define RFTS_PG_CFG0      8'he8
`define RFTS_PG_CFG1      8'he9
`define RFTS_PG_SES0      8'hf8
`define RFTS_PG_SES1      8'hf9
`define RFTS_CLS_NONE     2'h0
`define RFTS_CLS_ROM      2'h1
`define RFTS_CLS_MEM      2'h2
`define RFTS_CLS_REG      2'h3

`endif

// File: rtl/rfts_pkg.sv
`include "rfts_params.svh"

package rfts_pkg;

  // Protocol states of the tag.
  typedef enum logic [2:0] {st_idle, st_ready1, st_ready2, st_active, st_halt} rfts_state_t;

  // Kinds of answer the tag builds.
  typedef enum logic [3:0] {
    rk_none, rk_atqa, rk_uid1, rk_uid2, rk_sak1, rk_sak2, rk_mem, rk_ack, rk_nak
  } rfts_kind_t;

  // One checksum step over a byte, low bit first.
  function automatic logic [15:0] rfts_crc_byte(input logic [15:0] crc, input logic [7:0] data);
    logic [15:0] c;
    c = crc ^ {8'h00, data};
    for (int i = 0; i < 8; i++) begin
      c = c[0] ? ((c >> 1) ^ `RFTS_CRC_POLY) : (c >> 1);
    end
    return c;
  endfunction

  // Parity bit that makes byte plus parity odd.
  function automatic logic rfts_odd(input logic [7:0] d);
    return ~^d;
  endfunction

endpackage

// File: rtl/rfts_reader.sv
`timescale 1ns/10ps
`include "rfts_params.svh"

// Reader end: sends framed commands and unpacks tag answers.
module rfts_reader (
  // Clock, reset and enable.
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        ce,
  // Link to the tag.
  rfts_if.reader           link,
  // Command bytes.
  input  wire logic        cmd_valid,
  input  wire logic [7:0]  cmd_data,
  input  wire logic        cmd_last,
  input  wire logic        cmd_short,
  input  wire logic        cmd_crc,
  output logic             cmd_ready,
  // Answer bytes and verdict.
  output logic             rsp_valid,
  output logic [7:0]       rsp_data,
  output logic             rsp_done,
  output logic [13:0]      rsp_nbits,
  output logic             rsp_err,
  output logic             rsp_whole,
  output logic             rsp_crc_ok,
  output logic [8:0]       rsp_raw
);
  import rfts_pkg::*;
  logic [3:0] cnt_q;

  // A frame is cut short so that it never passes the tag's limit.
  wire [3:0]  lim = cmd_crc ? `RFTS_R2T_MAX_DATA : `RFTS_R2T_MAX_BYTES;
  wire        last_in = cmd_last || (cnt_q == lim - 4'h1);
  wire        load = cmd_valid && cmd_ready;

  // Counts data bytes of the frame in progress.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) cnt_q <= 4'h0;
    else if (ce && load) cnt_q <= (last_in || cmd_short) ? 4'h0 : cnt_q + 4'h1;
  end

  rfts_ser #(.SHORT_BITS(`RFTS_R2T_SHORT_BITS)) u_ser (
    .mclk(mclk), .rst(rst), .ce(ce), .in_valid(cmd_valid), .in_data(cmd_data),
    .in_last(last_in), .in_short(cmd_short), .in_crc(cmd_crc), .in_ready(cmd_ready),
    .busy(), .vld(link.r2t_vld), .sym(link.r2t_sym), .eof(link.r2t_eof)
  );

  rfts_des #(.MAX_BITS(`RFTS_T2R_MAX_BITS)) u_des (
    .mclk(mclk), .rst(rst), .ce(ce), .vld(link.t2r_vld), .sym(link.t2r_sym),
    .eof(link.t2r_eof), .byte_vld(rsp_valid), .byte_data(rsp_data), .done(rsp_done),
    .nbits(rsp_nbits), .err(rsp_err), .whole(rsp_whole), .crc_ok(rsp_crc_ok), .raw(rsp_raw)
  );
endmodule // rfts_reader

// File: rtl/rfts_tag.sv
`timescale 1ns/10ps
`include "rfts_params.svh"

// Word FIFO between the answer builder and the serializer.
module rfts_fifo #(
  parameter int W = 11,
  parameter int D = 16
) (
  // Clock, reset and enable.
  input  wire logic         mclk,
  input  wire logic         rst,
  input  wire logic         ce,
  // Filling side.
  input  wire logic         in_valid,
  input  wire logic [W-1:0] in_data,
  output logic              in_ready,
  // Draining side.
  output logic              out_valid,
  output logic [W-1:0]      out_data,
  input  wire logic         out_ready
);
  localparam int AW = $clog2(D);
  logic [W-1:0]    mem_q [D];
  logic [AW-1:0]   wp_q;
  logic [AW-1:0]   rp_q;
  logic [AW:0]     cnt_q;
  wire             push = ce && in_valid && in_ready;
  wire             pop  = ce && out_valid && out_ready;

  // Full and empty come from the word count.
  assign in_ready  = (cnt_q != (AW+1)'(D));
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem_q[rp_q];

  // Pointers wrap at the depth.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) wp_q <= (wp_q == AW'(D-1)) ? '0 : wp_q + 1'b1;
      if (pop) rp_q <= (rp_q == AW'(D-1)) ? '0 : rp_q + 1'b1;
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  // Storage needs no reset.
  always_ff @(posedge mclk) begin
    if (push) mem_q[wp_q] <= in_data;
  end
endmodule // rfts_fifo

// Frame serializer: start bit, bytes low bit first with odd parity, optional checksum.
module rfts_ser #(
  parameter int SHORT_BITS = 4
) (
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic       ce,
  // Units to send.
  input  wire logic       in_valid,
  input  wire logic [7:0] in_data,
  input  wire logic       in_last,
  input  wire logic       in_short,
  input  wire logic       in_crc,
  output logic            in_ready,
  output logic            busy,
  // Symbols out.
  output logic            vld,
  output logic [1:0]      sym,
  output logic            eof
);
  import rfts_pkg::*;
  logic [8:0]  sh_q;
  logic [3:0]  pos_q;
  logic [3:0]  len_q;
  logic        last_q;
  logic        cen_q;
  logic [1:0]  ph_q;
  logic [15:0] crc_q;
  wire         load     = in_valid && in_ready;
  wire         unit_end = (pos_q == len_q - 4'h1);

  // A unit is loaded while free; bits go out one per enabled cycle.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sh_q <= '0; pos_q <= '0; len_q <= '0; last_q <= 1'b0; cen_q <= 1'b0;
      ph_q <= '0; crc_q <= '0; in_ready <= 1'b1; busy <= 1'b0;
      vld <= 1'b0; sym <= '0; eof <= 1'b0;
    end else if (ce) begin
      vld <= 1'b0;
      eof <= 1'b0;
      if (load) begin
        sh_q     <= in_short ? {1'b0, in_data} : {rfts_odd(in_data), in_data};
        len_q    <= in_short ? 4'(SHORT_BITS) : `RFTS_BYTE_BITS;
        last_q   <= in_last | in_short;
        cen_q    <= in_crc & ~in_short;
        ph_q     <= 2'h0;
        pos_q    <= 4'h0;
        crc_q    <= rfts_crc_byte(busy ? crc_q : `RFTS_CRC_INIT, in_data);
        in_ready <= 1'b0;
        busy     <= 1'b1;
        if (!busy) begin
          vld <= 1'b1;
          sym <= `RFTS_SYM_SOC;
        end
      end else if (busy && !in_ready && ph_q == 2'h3) begin
        // End of frame stands alone, one cycle after the last bit, so no bit is miscounted.
        busy     <= 1'b0;
        in_ready <= 1'b1;
        eof      <= 1'b1;
      end else if (busy && !in_ready) begin
        vld <= 1'b1;
        sym <= sh_q[pos_q] ? `RFTS_SYM_ONE : `RFTS_SYM_ZERO;
        pos_q <= unit_end ? 4'h0 : pos_q + 4'h1;
        if (unit_end) begin
          if (ph_q == 2'h0 && !last_q) begin
            in_ready <= 1'b1;
          end else if (ph_q == 2'h0 && cen_q) begin
            ph_q  <= 2'h1;
            sh_q  <= {rfts_odd(crc_q[7:0]), crc_q[7:0]};
            len_q <= `RFTS_BYTE_BITS;
          end else if (ph_q == 2'h1) begin
            ph_q <= 2'h2;
            sh_q <= {rfts_odd(crc_q[15:8]), crc_q[15:8]};
          end else begin
            ph_q <= 2'h3;
          end
        end
      end
    end
  end
endmodule // rfts_ser

// Frame receiver: bit count, slot decode, parity and checksum residue.
module rfts_des #(
  parameter int MAX_BITS = 82,
  parameter int CW       = $clog2(MAX_BITS + 1)
) (
  input  wire logic          mclk,
  input  wire logic          rst,
  input  wire logic          ce,
  // Symbols in.
  input  wire logic          vld,
  input  wire logic [1:0]    sym,
  input  wire logic          eof,
  // Bytes and frame verdict.
  output logic               byte_vld,
  output logic [7:0]         byte_data,
  output logic               done,
  output logic [CW-1:0]      nbits,
  output logic               err,
  output logic               whole,
  output logic               crc_ok,
  output logic [8:0]         raw
);
  import rfts_pkg::*;
  logic          on_q;
  logic          bad_q;
  logic [3:0]    pos_q;
  logic [CW-1:0] cnt_q;
  logic [15:0]   crc_q;
  wire           bit_v = sym[0];

  // A start symbol always opens a fresh frame; broken frames still end with done and are flagged by err.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      on_q <= 1'b0; bad_q <= 1'b0; pos_q <= '0; cnt_q <= '0; crc_q <= '0; raw <= '0;
      byte_vld <= 1'b0; byte_data <= '0; done <= 1'b0; nbits <= '0;
      err <= 1'b0; whole <= 1'b0; crc_ok <= 1'b0;
    end else if (ce) begin
      byte_vld <= 1'b0;
      done     <= 1'b0;
      if (vld && sym == `RFTS_SYM_SOC) begin
        on_q  <= 1'b1;
        bad_q <= 1'b0;
        pos_q <= 4'h0;
        cnt_q <= '0;
        crc_q <= `RFTS_CRC_INIT;
      end else if (vld && on_q) begin
        if (sym == `RFTS_SYM_NONE) begin
          bad_q <= 1'b1;
        end else if (cnt_q >= CW'(MAX_BITS - 1)) begin
          bad_q <= 1'b1;
        end else begin
          raw[pos_q] <= bit_v;
          cnt_q <= cnt_q + 1'b1;
          pos_q <= (pos_q == 4'h8) ? 4'h0 : pos_q + 4'h1;
          if (pos_q == 4'h8) begin
            if (!(^{bit_v, raw[7:0]})) bad_q <= 1'b1;
            byte_vld  <= 1'b1;
            byte_data <= raw[7:0];
            crc_q     <= rfts_crc_byte(crc_q, raw[7:0]);
          end
        end
      end
      if (eof && on_q) begin
        on_q   <= 1'b0;
        done   <= 1'b1;
        nbits  <= cnt_q;
        err    <= bad_q;
        whole  <= (pos_q == 4'h0);
        crc_ok <= (crc_q == 16'h0000);
      end
    end
  end
endmodule // rfts_des

module rfts_tag #(
  parameter logic [55:0] UID = 56'h66554433221105, // Arbitrary serial number.
  parameter int          FD  = 16
) (
  // Clock, reset and enable.
  input  wire logic          mclk,
  input  wire logic          rst,
  input  wire logic          ce,
  // Link to the reader.
  rfts_if.tag                link,
  // Status.
  output rfts_pkg::rfts_state_t tag_state,
  output logic               halted,
  output logic               rx_error
);
  import rfts_pkg::*;
  rfts_state_t state_q, state_d;
  rfts_kind_t  kind_d, kind_q;
  logic        halted_q, halted_d, ss_q, ss_d, err_q, err_d, wr_mem, gen_busy_q;
  logic [7:0]  sec_q, sec_d, buf_q [9], gw_byte;
  logic [7:0]  mem_q [1024];
  logic [3:0]  nb_q;
  logic [10:0] len_d, base_d, len_q, base_q, idx_q;
  logic        rb_vld, rf_done, rf_err, rf_whole, rf_crc, ser_busy, ser_rdy;
  logic [7:0]  rb_data;
  logic [6:0]  rf_nbits;
  logic [8:0]  rf_raw;
  logic        f_in_rdy, f_out_vld;
  logic [10:0] f_out;

  // Page class in the 1k map; the pass-through buffer has no page here.
  function automatic logic [1:0] pg_class(input logic [7:0] sec, input logic [7:0] pg);
    if (sec == `RFTS_SEC_MAIN && pg <= `RFTS_PG_ROM_LAST) return `RFTS_CLS_ROM;
    if (sec == `RFTS_SEC_MAIN && pg <= `RFTS_PG_MEM_LAST) return `RFTS_CLS_MEM;
    if (sec == `RFTS_SEC_MAIN && (pg == `RFTS_PG_CFG0 || pg == `RFTS_PG_CFG1))
      return `RFTS_CLS_REG;
    if (sec == `RFTS_SEC_SES && (pg == `RFTS_PG_SES0 || pg == `RFTS_PG_SES1))
      return `RFTS_CLS_REG;
    return `RFTS_CLS_NONE;
  endfunction

  rfts_des #(.MAX_BITS(`RFTS_R2T_MAX_BITS)) u_des (
    .mclk(mclk), .rst(rst), .ce(ce), .vld(link.r2t_vld), .sym(link.r2t_sym),
    .eof(link.r2t_eof), .byte_vld(rb_vld), .byte_data(rb_data), .done(rf_done),
    .nbits(rf_nbits), .err(rf_err), .whole(rf_whole), .crc_ok(rf_crc), .raw(rf_raw)
  );

  // Decode of the frame just received; frames during an answer are dropped.
  wire [7:0]  u0 = UID[7:0],   u1 = UID[15:8],  u2 = UID[23:16], u3 = UID[31:24];
  wire [7:0]  u4 = UID[39:32], u5 = UID[47:40], u6 = UID[55:48];
  wire [7:0]  bcc1 = `RFTS_CT ^ u0 ^ u1 ^ u2;
  wire [7:0]  bcc2 = u3 ^ u4 ^ u5 ^ u6;
  wire        frm = rf_done && !gen_busy_q && !f_out_vld && !ser_busy;
  wire        sh7 = frm && !rf_err && rf_nbits == 7'(`RFTS_R2T_SHORT_BITS);
  wire        ok = frm && !rf_err && rf_whole;
  wire        cok = ok && rf_crc;
  wire        reqa = sh7 && rf_raw[6:0] == `RFTS_REQA;
  wire        wupa = sh7 && rf_raw[6:0] == `RFTS_WUPA;
  wire [39:0] sel_v = {buf_q[2], buf_q[3], buf_q[4], buf_q[5], buf_q[6]};
  wire        anti = ok && nb_q == 4'h2 && buf_q[1] == `RFTS_NVB_ANTI;
  wire        anti1 = anti && buf_q[0] == `RFTS_CMD_CL1;
  wire        anti2 = anti && buf_q[0] == `RFTS_CMD_CL2;
  wire        selc = cok && nb_q == 4'h9 && buf_q[1] == `RFTS_NVB_SEL;
  wire        sel1 = selc && buf_q[0] == `RFTS_CMD_CL1 && sel_v == {`RFTS_CT, u0, u1, u2, bcc1};
  wire        sel2 = selc && buf_q[0] == `RFTS_CMD_CL2 && sel_v == {u3, u4, u5, u6, bcc2};
  wire        hlta = cok && nb_q == 4'h4 && buf_q[0] == `RFTS_CMD_HLTA && buf_q[1] == 8'h00;
  wire        rd = cok && nb_q == 4'h4 && buf_q[0] == `RFTS_CMD_READ;
  wire        frd = cok && nb_q == 4'h5 && buf_q[0] == `RFTS_CMD_FREAD;
  wire        wr = cok && nb_q == 4'h8 && buf_q[0] == `RFTS_CMD_WRITE;
  wire        ss1 = cok && nb_q == 4'h4 && buf_q[0] == `RFTS_CMD_SSEL && buf_q[1] == `RFTS_SSEL_ARG;
  wire        ss2 = cok && nb_q == 4'h6 && ss_q;
  wire [1:0]  cls_a = pg_class(sec_q, buf_q[1]);
  wire [1:0]  cls_b = pg_class(sec_q, buf_q[2]);
  wire [8:0]  span = {1'b0, buf_q[2]} - {1'b0, buf_q[1]} + 9'h001;
  wire        rst_wait = halted_q;
  rfts_state_t wait_st;
  assign wait_st = rst_wait ? st_halt : st_idle;

  // Protocol state machine; only reader frames move it.
  always_comb begin
    state_d = state_q; halted_d = halted_q; sec_d = sec_q; ss_d = frm ? 1'b0 : ss_q;
    kind_d = rk_none; len_d = 11'h001; base_d = {1'b0, buf_q[1], 2'b00}; wr_mem = 1'b0;
    err_d = 1'b0;
    case (state_q)
      st_idle: begin
        if (reqa || wupa) begin
          state_d = st_ready1; kind_d = rk_atqa; len_d = 11'h002;
        end else if (frm) err_d = 1'b1;
      end
      st_halt: begin
        if (wupa) begin
          state_d = st_ready1; kind_d = rk_atqa; len_d = 11'h002;
        end else if (frm) err_d = 1'b1;
      end
      st_ready1: begin
        if (anti1) begin
          kind_d = rk_uid1; len_d = 11'h005;
        end else if (sel1) begin
          state_d = st_ready2; kind_d = rk_sak1;
        end else if (frm) begin
          state_d = wait_st; err_d = 1'b1;
        end
      end
      st_ready2: begin
        if (anti2) begin
          kind_d = rk_uid2; len_d = 11'h005;
        end else if (sel2) begin
          state_d = st_active; kind_d = rk_sak2;
        end else if (frm) begin
          state_d = wait_st; err_d = 1'b1;
        end
      end
      st_active: begin
        if (hlta) begin
          state_d = st_halt; halted_d = 1'b1; sec_d = `RFTS_SEC_MAIN;
        end else if (rd) begin
          kind_d = (cls_a != `RFTS_CLS_NONE) ? rk_mem : rk_nak;
          len_d = (cls_a != `RFTS_CLS_NONE) ? `RFTS_READ_LEN : 11'h001;
        end else if (frd) begin
          if (cls_a != `RFTS_CLS_NONE && cls_b != `RFTS_CLS_NONE && buf_q[2] >= buf_q[1]) begin
            kind_d = rk_mem; len_d = {span, 2'b00};
          end else kind_d = rk_nak;
        end else if (wr) begin
          wr_mem = (cls_a == `RFTS_CLS_MEM) && buf_q[1] >= `RFTS_PG_WR_FIRST;
          kind_d = (wr_mem || cls_a == `RFTS_CLS_REG) ? rk_ack : rk_nak;
        end else if (ss1) begin
          kind_d = rk_ack; ss_d = 1'b1;
        end else if (ss2) begin
          sec_d = buf_q[0];
        end else if (frm) begin
          state_d = wait_st; err_d = 1'b1; sec_d = `RFTS_SEC_MAIN;
        end
      end
      default: state_d = st_idle;
    endcase
  end

  // Answer bytes; reads walk pages byte 0 to 3 and pad bad space with 00h.
  wire [10:0] ma = base_q + idx_q;
  wire [1:0]  mcls = pg_class(sec_q, ma[9:2]);
  wire [63:0] rom_v = {8'h00, UID};
  wire [63:0] uid1_v = {24'h0, bcc1, u2, u1, u0, `RFTS_CT};
  wire [63:0] uid2_v = {24'h0, bcc2, u6, u5, u4, u3};
  wire        gw_last = (idx_q == len_q - 11'h001);
  always_comb begin
    case (kind_q)
      rk_atqa: gw_byte = idx_q[0] ? `RFTS_ATQA1 : `RFTS_ATQA0;
      rk_uid1: gw_byte = uid1_v[{idx_q[2:0], 3'b000} +: 8];
      rk_uid2: gw_byte = uid2_v[{idx_q[2:0], 3'b000} +: 8];
      rk_sak1: gw_byte = `RFTS_SAK_MORE;
      rk_sak2: gw_byte = `RFTS_SAK_DONE;
      rk_ack:  gw_byte = `RFTS_ACK;
      rk_mem: begin
        if (ma[10] || mcls == `RFTS_CLS_NONE) gw_byte = 8'h00;
        else if (mcls == `RFTS_CLS_ROM) gw_byte = rom_v[{ma[2:0], 3'b000} +: 8];
        else if (mcls == `RFTS_CLS_MEM) gw_byte = mem_q[ma[9:0]];
        else gw_byte = 8'h00;
      end
      default: gw_byte = `RFTS_NAK;
    endcase
  end
  wire        gw_short = (kind_q == rk_ack) || (kind_q == rk_nak);
  wire        gw_crc = (kind_q == rk_sak1) || (kind_q == rk_sak2) || (kind_q == rk_mem);
  wire        push = gen_busy_q && f_in_rdy;

  // Control registers.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_q <= st_idle; halted_q <= 1'b0; sec_q <= `RFTS_SEC_MAIN; ss_q <= 1'b0; err_q <= 1'b0;
    end else if (ce) begin
      state_q <= state_d; halted_q <= halted_d; sec_q <= sec_d; ss_q <= ss_d; err_q <= err_d;
    end
  end

  // Answer builder, stalled by the FIFO.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      gen_busy_q <= 1'b0; kind_q <= rk_none; idx_q <= '0; len_q <= '0; base_q <= '0; nb_q <= '0;
    end else if (ce) begin
      if (link.r2t_vld && link.r2t_sym == `RFTS_SYM_SOC) nb_q <= 4'h0;
      else if (rb_vld && nb_q != `RFTS_R2T_MAX_BYTES) nb_q <= nb_q + 4'h1;
      if (kind_d != rk_none) begin
        gen_busy_q <= 1'b1; kind_q <= kind_d; idx_q <= '0; len_q <= len_d; base_q <= base_d;
      end else if (push) begin
        idx_q <= idx_q + 11'h001;
        if (gw_last) gen_busy_q <= 1'b0;
      end
    end
  end

  // Received bytes and user memory hold data only.
  always_ff @(posedge mclk) begin
    if (ce && rb_vld && nb_q != `RFTS_R2T_MAX_BYTES) buf_q[nb_q] <= rb_data;
    if (ce && wr_mem) begin
      for (int i = 0; i < 4; i++) begin
        mem_q[{buf_q[1], 2'(i)}] <= buf_q[2 + i];
      end
    end
  end

  rfts_fifo #(.W(11), .D(FD)) u_fifo (
    .mclk(mclk), .rst(rst), .ce(ce), .in_valid(gen_busy_q),
    .in_data({gw_short, gw_crc, gw_last, gw_byte}), .in_ready(f_in_rdy),
    .out_valid(f_out_vld), .out_data(f_out), .out_ready(ser_rdy)
  );

  rfts_ser #(.SHORT_BITS(`RFTS_T2R_SHORT_BITS)) u_ser (
    .mclk(mclk), .rst(rst), .ce(ce), .in_valid(f_out_vld), .in_data(f_out[7:0]),
    .in_last(f_out[8]), .in_short(f_out[10]), .in_crc(f_out[9]), .in_ready(ser_rdy),
    .busy(ser_busy), .vld(link.t2r_vld), .sym(link.t2r_sym), .eof(link.t2r_eof)
  );

  assign tag_state = state_q;
  assign halted    = halted_q;
  assign rx_error  = err_q;
endmodule // rfts_tag

// File: tb/rf_tag_protocol_state_test.sv
`timescale 1ns/10ps
module rf_tag_protocol_state_test;
  import rfts_pkg::*;
  logic        mclk = 0, rst = 1, cmd_valid = 0, cmd_last = 0, cmd_short = 0, cmd_crc = 0;
  logic [7:0]  cmd_data = 8'h00, rsp_data, rb[0:31];
  logic        cmd_ready, rsp_valid, rsp_done, rsp_err, rsp_whole, rsp_crc_ok, halted, rx_error, rxs;
  logic [13:0] rsp_nbits;
  logic [8:0]  rsp_raw;
  rfts_state_t tag_state;
  int          mismatches = 0, n_tests = 0, nb = 0;
  rfts_if link();
  rfts_tag i_rfts_tag (.mclk, .rst, .ce(1'b1), .link(link.tag), .tag_state, .halted, .rx_error);
  rfts_reader i_rfts_reader (.mclk, .rst, .ce(1'b1), .link(link.reader), .cmd_valid, .cmd_data,
    .cmd_last, .cmd_short, .cmd_crc, .cmd_ready, .rsp_valid, .rsp_data, .rsp_done, .rsp_nbits,
    .rsp_err, .rsp_whole, .rsp_crc_ok, .rsp_raw);
  rfts_monitor i_rfts_monitor (.mclk, .rst, .r2t_vld(link.r2t_vld), .r2t_sym(link.r2t_sym),
    .r2t_eof(link.r2t_eof), .t2r_vld(link.t2r_vld), .t2r_sym(link.t2r_sym),
    .t2r_eof(link.t2r_eof));
  // Clock and answer collection.
  always #25 mclk = ~mclk;
  always @(posedge mclk) begin
    if (rsp_valid) rb[nb] <= rsp_data;
    if (rsp_valid) nb <= nb + 1;
    if (rx_error) rxs <= 1'b1;
  end
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
      mismatches++;
    end
  endtask
  // Sends one frame, waits for the answer, compares leading bytes and state.
  task automatic xfer(input logic [7:0] b[$], input logic s, c, input logic [7:0] e[$],
                      input rfts_state_t st);
    nb <= 0;
    rxs <= 1'b0;
    foreach (b[i]) begin
      {cmd_valid, cmd_data, cmd_last, cmd_short, cmd_crc} <= {1'b1, b[i], i == b.size() - 1, s, c};
      @(posedge mclk);
      while (cmd_ready !== 1'b1) @(posedge mclk);
    end
    cmd_valid <= 1'b0;
    for (int i = 0; i < 400 && rsp_done !== 1'b1; i++) @(posedge mclk);
    repeat (30) @(posedge mclk);
    foreach (e[i]) chk("answer byte", e[i], rb[i]);
    chk("state", st, tag_state);
  endtask
  task automatic t_wake;
    xfer('{8'h30}, 1, 0, '{}, st_idle);
    chk("idle error", 1, rxs);
    xfer('{8'h26}, 1, 0, '{8'h44, 8'h00}, st_ready1);
    $display("wake test done");
  endtask
  task automatic t_sel;
    xfer('{8'h93, 8'h20}, 0, 0, '{8'h88, 8'h05, 8'h11, 8'h22, 8'hbe}, st_ready1);
    xfer('{8'h93, 8'h70, 8'h88, 8'h05, 8'h11, 8'h22, 8'hbe}, 0, 1, '{8'h04}, st_ready2);
    xfer('{8'h95, 8'h20}, 0, 0, '{8'h33, 8'h44, 8'h55, 8'h66, 8'h44}, st_ready2);
    xfer('{8'h95, 8'h70, 8'h33, 8'h44, 8'h55, 8'h66, 8'h44}, 0, 1, '{8'h00}, st_active);
    chk("sak crc", 1, rsp_crc_ok);
    chk("sak error", 0, rsp_err);
    $display("select test done");
  endtask
  task automatic t_mem;
    xfer('{8'ha2, 8'he1, 8'hde, 8'had, 8'hbe, 8'hef}, 0, 1, '{}, st_active);
    chk("ack", 4'ha, rsp_raw[3:0]);
    xfer('{8'ha2, 8'he2, 8'h01, 8'h02, 8'h03, 8'h04}, 0, 1, '{}, st_active);
    xfer('{8'h30, 8'he1}, 0, 1, '{8'hde, 8'had, 8'hbe, 8'hef, 8'h01, 8'h02, 8'h03, 8'h04, 8'h00,
         8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00}, st_active);
    chk("read length", 18, nb);
    chk("read crc", 1, rsp_crc_ok);
    chk("read whole", 1, rsp_whole);
    chk("read bits", 16'h00a2, rsp_nbits);
    xfer('{8'h30, 8'he3}, 0, 1, '{}, st_active);
    chk("nak", 16'h0004, {rsp_raw[3:0], rsp_nbits[7:0]});
    xfer('{8'h50, 8'h00}, 0, 1, '{}, st_halt);
    chk("halted", 1, halted);
    $display("memory test done");
  endtask
  task automatic t_halt;
    xfer('{8'h26}, 1, 0, '{}, st_halt);
    chk("halt answers", 0, nb);
    xfer('{8'h52}, 1, 0, '{8'h44, 8'h00}, st_ready1);
    xfer('{8'h30}, 1, 0, '{}, st_halt);
    $display("halt test done");
  endtask
  task automatic wrap_up;
    $display("%0d checks, %0d mismatches", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Main sequence and watchdog.
  initial begin
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    t_wake;
    t_sel;
    t_mem;
    t_halt;
    wrap_up;
  end
  initial begin
    #2000000;
    mismatches++;
    wrap_up;
  end
endmodule // rf_tag_protocol_state_test

// File: tb/rfts_monitor.sv
`timescale 1ns/10ps
`include "rfts_params.svh"
// Watches both directions of the symbol link between reader and tag.
module rfts_monitor (
  // Clock and reset.
  input wire logic       mclk,
  input wire logic       rst,
  // Link symbols.
  input wire logic       r2t_vld,
  input wire logic [1:0] r2t_sym,
  input wire logic       r2t_eof,
  input wire logic       t2r_vld,
  input wire logic [1:0] t2r_sym,
  input wire logic       t2r_eof
);
  logic [6:0] rcnt_q;
  logic [3:0] gcnt_q;
  logic [8:0] sh_q;
  logic       tin_q;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  sequence s_tstart; t2r_vld && t2r_sym == `RFTS_SYM_SOC; endsequence
  sequence s_tbit; t2r_vld && t2r_sym != `RFTS_SYM_SOC; endsequence
  // Counts reader bits, tag bits within a byte group, and whether a tag frame is open.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rcnt_q <= '0;
      gcnt_q <= '0;
      sh_q   <= '0;
      tin_q  <= 1'b0;
    end else begin
      if (r2t_vld) rcnt_q <= (r2t_sym == `RFTS_SYM_SOC) ? 7'h01 : rcnt_q + (rcnt_q != 7'h7f);
      if (r2t_eof) rcnt_q <= '0;
      if (t2r_vld) gcnt_q <= (t2r_sym == `RFTS_SYM_SOC || gcnt_q == 4'h8) ? 4'h0 : gcnt_q + 4'h1;
      if (t2r_vld) sh_q <= {t2r_sym[0], sh_q[8:1]};
      tin_q <= (tin_q || (t2r_vld && t2r_sym == `RFTS_SYM_SOC)) && !t2r_eof;
    end
  end
  AST_T2R_START_ONCE: assert property (s_tstart |-> !tin_q) else $error("tag restarts frame");
  AST_T2R_BIT_IN_FRAME: assert property (s_tbit |-> tin_q) else $error("tag bit outside frame");
  AST_R2T_BIT_IN_FRAME:
    assert property (r2t_vld && r2t_sym != `RFTS_SYM_SOC |-> rcnt_q != 7'h00) else $error("no start");
  AST_T2R_PARITY:
    assert property (s_tbit and gcnt_q == 4'h8 |-> ^{t2r_sym[0], sh_q[8:1]}) else $error("parity");
  AST_T2R_EOF_WHOLE:
    assert property (t2r_eof |-> tin_q && !t2r_vld && gcnt_q inside {4'h0, 4'h4}) else $error("eof");
  AST_R2T_MAX_LEN: assert property (r2t_eof |-> rcnt_q <= 7'h52) else $error("reader frame long");
  AST_ANSWER_AFTER_CMD:
    assert property (s_tstart |-> $past(r2t_eof, 2) || $past(r2t_eof, 3) || $past(r2t_eof, 4))
      else $error("tag spoke unasked");
  AST_HALF_DUPLEX: assert property (t2r_vld |-> !r2t_vld) else $error("both talk");
endmodule // rfts_monitor
